// ---- hw/mtr_defines.svh ----
// Purpose: Offsets, field positions, reset values and timing counts for the motion parameter block.
// Assumes: Plain register port with 16-bit word offsets and 32-bit data.
// Notes: Offsets are the register addresses as seen on the port.
`ifndef MTR_DEFINES_SVH
`define MTR_DEFINES_SVH
`define MTR_A_VEL_ACT     16'h355A
`define MTR_A_SPD_WIN     16'h355C
`define MTR_A_SPD_TIME    16'h355E
`define MTR_A_ZERO_THR    16'h3560
`define MTR_A_ZERO_TIME   16'h3562
`define MTR_A_TRQ_TGT     16'h3564
`define MTR_A_TRQ_MAX     16'h3566
`define MTR_A_TRQ_DEM     16'h356A
`define MTR_A_TRQ_FB      16'h3570
`define MTR_A_POS_TGT     16'h3576
`define MTR_A_HOME_OFS    16'h357A
`define MTR_A_SIGN_CTL    16'h357E
`define MTR_A_SPD_CAP     16'h3580
`define MTR_A_CRUISE      16'h3584
`define MTR_A_LIM_MIN     16'h3700
`define MTR_A_LIM_MAX     16'h3800
`define MTR_A_CTRL        16'h3500
`define MTR_A_MODE        16'h3502
`define MTR_A_SPD_TGT     16'h3504
`define MTR_A_STATUS      16'h3506
`define MTR_RST_SPD_WIN   16'h000A
`define MTR_RST_ZERO_THR  16'h000A
`define MTR_RST_TRQ_MAX   16'h0DAC
`define MTR_RST_SPD_CAP   32'h32000000
`define MTR_RST_CRUISE    32'h00D55555
`define MTR_RST_LIM_MIN   32'h80000000
`define MTR_RST_LIM_MAX   32'h7FFFFFFF
`define MTR_TRQ_FULL      16'sh0FA0
`define MTR_CTRL_ENABLE   0
`define MTR_CTRL_SLACT    1
`define MTR_CTRL_REL      6
`define MTR_CTRL_HERR_CLR 8
`define MTR_SIGN_TRQ      5
`define MTR_SIGN_SPD      6
`define MTR_SIGN_POS      7
`define MTR_TICK_NS       1000000
`define MTR_CLK_NS        8
`define MTR_TICK_CYCLES   (`MTR_TICK_NS / `MTR_CLK_NS)
`endif

// ---- hw/mtr_pkg.sv ----
// Purpose: Types shared by the motion parameter block.
// Assumes: Nothing beyond the defines header.
// Notes: Operation mode codes are the values software writes.
package mtr_pkg;
  typedef enum logic [15:0] {
    MTR_MODE_PP = 16'h0001,
    MTR_MODE_PV = 16'h0003,
    MTR_MODE_PT = 16'h0004,
    MTR_MODE_HM = 16'h0006,
    MTR_MODE_IP = 16'h0007
  } mtr_opmode_e;
  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } mtr_req_s;
  typedef struct packed {
    logic home_done;
    logic home_err;
    logic zero_speed;
    logic speed_reached;
  } mtr_status_s;
endpackage

// ---- hw/mtr_motion_params.sv ----
// Purpose: Motion parameter registers, speed-reach and zero-speed detection, torque, position and speed references.
// Assumes: Motion core inputs are on i_core_clk; host port is a plain single-cycle strobe port.
// Notes: Millisecond tick derived from the core clock by a divider.
// Notes on behaviour
// R1 - PV: status bit 10 after window time
// R2 - Speed reached only valid enabled and PV
// R3 - Speed-reach time register ms, default zero
// R4 - Zero speed needs threshold held threshold-time
// R5 - Zero speed computed whether enabled or not
// R6 - Zero speed reported only in PV mode
// R7 - Torque scale: 1000 equals rated torque
// R8 - Target torque -4000..4000 drives torque demand
// R9 - Torque demand clamped to max limit 0..4000
// R10 - Control bit 6 clear: absolute target
// R11 - Control bit 6 set: relative increment
// R12 - Homing completion loads home offset position
// R13 - Home offset applies after homing, bit 15
// R14 - Offset beyond soft limits raises home error
// R15 - Soft limits inactive until homing done
// R16 - Polarity bit 7 negates position reference
// R17 - Polarity bit 6 negates speed reference
// R18 - Polarity bit 5 negates torque; others ignored
// R19 - Speed reference capped by max profile velocity
// R20 - Profile velocity latched at next displacement reference
// R21 - Qualify counters restart, count millisecond ticks
`include "mtr_defines.svh"
module mtr_motion_params #(
  parameter int unsigned TICK_CYCLES = `MTR_TICK_CYCLES
) (
  input  wire logic               i_core_clk,
  input  wire logic               i_rstn,
  input  wire mtr_pkg::mtr_req_s  i_req,
  output logic [31:0]             o_rdata,
  input  wire logic signed [31:0] i_vel_actual,
  input  wire logic signed [15:0] i_trq_feedback,
  input  wire logic signed [31:0] i_pos_actual,
  input  wire logic               i_homing_done,
  input  wire logic               i_new_setpoint,
  output logic                    o_speed_reached,
  output logic                    o_zero_speed,
  output logic signed [15:0]      o_trq_demand,
  output logic signed [31:0]      o_speed_ref,
  output logic signed [31:0]      o_pos_goal,
  output logic [31:0]             o_cruise_speed,
  output logic                    o_pos_load,
  output logic signed [31:0]      o_pos_load_value,
  output logic                    o_home_done,
  output logic                    o_home_error,
  output logic                    o_soft_limit_hit
);
  logic [15:0]        spd_win_q, spd_time_q, zero_thr_q, zero_time_q, sign_q, ctrl_q, mode_q;
  logic signed [15:0] trq_tgt_q, trq_max_q;
  logic signed [31:0] pos_tgt_q, home_ofs_q, lim_min_q, lim_max_q, spd_tgt_q;
  logic [31:0]        spd_cap_q, cruise_q;
  logic [31:0]        tick_cnt_q;
  logic               tick;
  logic [15:0]        spd_cnt_q, zero_cnt_q;
  logic               home_done_q, home_err_q, pos_load_q;
  logic               wr, herr_clr;
  logic signed [15:0] wtrq;
  logic signed [16:0] trq_signed;
  logic signed [32:0] spd_neg, spd_cap_s, spd_diff, spd_abs, vel_abs;
  logic               spd_in_win, zero_in_win, spd_ok, zero_ok, is_pv;
  mtr_pkg::mtr_status_s status;

  assign wr   = i_req.wr;
  assign wtrq = i_req.wdata[15:0];

  // Register writes; torque values are clamped into their legal range on entry.
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      spd_win_q   <= `MTR_RST_SPD_WIN;
      spd_time_q  <= 16'h0000; // see R3
      zero_thr_q  <= `MTR_RST_ZERO_THR;
      zero_time_q <= 16'h0000;
      trq_tgt_q   <= 16'sh0000;
      trq_max_q   <= `MTR_RST_TRQ_MAX;
      pos_tgt_q   <= 32'sh00000000;
      home_ofs_q  <= 32'sh00000000;
      sign_q      <= 16'h0000;
      spd_cap_q   <= `MTR_RST_SPD_CAP;
      cruise_q    <= `MTR_RST_CRUISE;
      lim_min_q   <= `MTR_RST_LIM_MIN;
      lim_max_q   <= `MTR_RST_LIM_MAX;
      ctrl_q      <= 16'h0000;
      mode_q      <= 16'h0000;
      spd_tgt_q   <= 32'sh00000000;
    end else if (wr) begin
      case (i_req.addr)
        `MTR_A_SPD_WIN:   spd_win_q   <= i_req.wdata[15:0];
        `MTR_A_SPD_TIME:  spd_time_q  <= i_req.wdata[15:0]; // see R3
        `MTR_A_ZERO_THR:  zero_thr_q  <= i_req.wdata[15:0];
        `MTR_A_ZERO_TIME: zero_time_q <= i_req.wdata[15:0];
        `MTR_A_TRQ_TGT: begin // see R8
          if (wtrq > `MTR_TRQ_FULL) begin
            trq_tgt_q <= `MTR_TRQ_FULL;
          end else if (wtrq < -`MTR_TRQ_FULL) begin
            trq_tgt_q <= -`MTR_TRQ_FULL;
          end else begin
            trq_tgt_q <= wtrq;
          end
        end
        `MTR_A_TRQ_MAX: begin // see R9
          if (wtrq > `MTR_TRQ_FULL) begin
            trq_max_q <= `MTR_TRQ_FULL;
          end else if (wtrq < 16'sh0000) begin
            trq_max_q <= 16'sh0000;
          end else begin
            trq_max_q <= wtrq;
          end
        end
        `MTR_A_POS_TGT:  pos_tgt_q  <= i_req.wdata;
        `MTR_A_HOME_OFS: home_ofs_q <= i_req.wdata;
        `MTR_A_SIGN_CTL: sign_q     <= i_req.wdata[15:0];
        `MTR_A_SPD_CAP:  spd_cap_q  <= i_req.wdata;
        `MTR_A_CRUISE:   cruise_q   <= i_req.wdata;
        `MTR_A_LIM_MIN:  lim_min_q  <= i_req.wdata;
        `MTR_A_LIM_MAX:  lim_max_q  <= i_req.wdata;
        `MTR_A_CTRL:     ctrl_q     <= i_req.wdata[15:0];
        `MTR_A_MODE:     mode_q     <= i_req.wdata[15:0];
        `MTR_A_SPD_TGT:  spd_tgt_q  <= i_req.wdata;
        default: ;
      endcase
    end
  end

  assign herr_clr = wr && (i_req.addr == `MTR_A_CTRL) && i_req.wdata[`MTR_CTRL_HERR_CLR];

  // Millisecond tick divider.
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tick_cnt_q <= 32'h00000000;
    end else if (tick_cnt_q == TICK_CYCLES - 1) begin
      tick_cnt_q <= 32'h00000000; // see R21
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h00000001;
    end
  end
  assign tick = (tick_cnt_q == TICK_CYCLES - 1);

  // Speed reference: polarity first, then the profile velocity cap in both directions.
  always_comb begin
    spd_neg   = sign_q[`MTR_SIGN_SPD] ? -{spd_tgt_q[31], spd_tgt_q} : {spd_tgt_q[31], spd_tgt_q}; // see R17
    spd_cap_s = {1'b0, spd_cap_q};
    if (spd_neg > spd_cap_s) begin
      o_speed_ref = spd_cap_q[31:0]; // see R19
    end else if (spd_neg < -spd_cap_s) begin
      o_speed_ref = 32'(-spd_cap_s); // see R19
    end else begin
      o_speed_ref = spd_neg[31:0];
    end
    spd_diff = {o_speed_ref[31], o_speed_ref} - {i_vel_actual[31], i_vel_actual};
    spd_abs  = spd_diff[32] ? -spd_diff : spd_diff;
    vel_abs  = i_vel_actual[31] ? -{1'b1, i_vel_actual} : {1'b0, i_vel_actual};
  end

  assign spd_in_win  = (spd_abs <= {17'h00000, spd_win_q});
  assign zero_in_win = (vel_abs <= {17'h00000, zero_thr_q});
  assign spd_ok      = spd_in_win && (spd_cnt_q >= spd_time_q);
  assign zero_ok     = zero_in_win && (zero_cnt_q >= zero_time_q);
  assign is_pv       = (mode_q == mtr_pkg::MTR_MODE_PV);

  // Qualifying counters restart whenever the window is left and saturate at full scale.
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      spd_cnt_q <= 16'h0000;
    end else if (!spd_in_win) begin
      spd_cnt_q <= 16'h0000; // see R21
    end else if (tick && spd_cnt_q != 16'hFFFF) begin
      spd_cnt_q <= spd_cnt_q + 16'h0001; // see R1
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      zero_cnt_q <= 16'h0000;
    end else if (!zero_in_win) begin
      zero_cnt_q <= 16'h0000; // see R21
    end else if (tick && zero_cnt_q != 16'hFFFF) begin
      zero_cnt_q <= zero_cnt_q + 16'h0001; // see R4 R5
    end
  end

  assign o_speed_reached = spd_ok && is_pv && ctrl_q[`MTR_CTRL_ENABLE]; // see R1 R2
  assign o_zero_speed    = zero_ok && is_pv; // see R4 R6

  // Torque demand in 0.1 percent of rated torque, polarity then clamp.
  always_comb begin
    trq_signed = sign_q[`MTR_SIGN_TRQ] ? -{trq_tgt_q[15], trq_tgt_q} : {trq_tgt_q[15], trq_tgt_q}; // see R18 R7
    if (trq_signed > $signed({trq_max_q[15], trq_max_q})) begin
      o_trq_demand = trq_max_q; // see R9
    end else if (trq_signed < -$signed({trq_max_q[15], trq_max_q})) begin
      o_trq_demand = -trq_max_q; // see R9
    end else begin
      o_trq_demand = trq_signed[15:0]; // see R8
    end
  end

  // Position goal and cruise speed are taken only on a new displacement reference.
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pos_goal     <= 32'sh00000000;
      o_cruise_speed <= `MTR_RST_CRUISE;
    end else if (i_new_setpoint) begin
      o_cruise_speed <= cruise_q; // see R20
      if (ctrl_q[`MTR_CTRL_REL]) begin
        o_pos_goal <= i_pos_actual + (sign_q[`MTR_SIGN_POS] ? -pos_tgt_q : pos_tgt_q); // see R11 R16
      end else begin
        o_pos_goal <= sign_q[`MTR_SIGN_POS] ? -pos_tgt_q : pos_tgt_q; // see R10 R16
      end
    end
  end

  // Homing completion: load the offset, flag homing done, check the offset against the limits.
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      home_done_q      <= 1'b0;
      pos_load_q       <= 1'b0;
      o_pos_load_value <= 32'sh00000000;
    end else begin
      pos_load_q <= i_homing_done; // see R12
      if (i_homing_done) begin
        home_done_q      <= 1'b1; // see R13
        o_pos_load_value <= home_ofs_q; // see R12
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      home_err_q <= 1'b0;
    end else if (i_homing_done && (home_ofs_q < lim_min_q || home_ofs_q > lim_max_q)) begin
      home_err_q <= 1'b1; // see R14
    end else if (herr_clr) begin
      home_err_q <= 1'b0;
    end
  end

  assign o_pos_load       = pos_load_q;
  assign o_home_done      = home_done_q;
  assign o_home_error     = home_err_q;
  assign o_soft_limit_hit = home_done_q && ctrl_q[`MTR_CTRL_SLACT] &&
                            (i_pos_actual < lim_min_q || i_pos_actual > lim_max_q); // see R15

  assign status.home_done     = home_done_q;
  assign status.home_err      = home_err_q;
  assign status.zero_speed    = o_zero_speed;
  assign status.speed_reached = o_speed_reached;

  // Read data stands one cycle after the read strobe; unmapped offsets read zero.
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= 32'h00000000;
    end else if (i_req.rd) begin
      case (i_req.addr)
        `MTR_A_VEL_ACT:   o_rdata <= i_vel_actual;
        `MTR_A_SPD_WIN:   o_rdata <= {16'h0000, spd_win_q};
        `MTR_A_SPD_TIME:  o_rdata <= {16'h0000, spd_time_q};
        `MTR_A_ZERO_THR:  o_rdata <= {16'h0000, zero_thr_q};
        `MTR_A_ZERO_TIME: o_rdata <= {16'h0000, zero_time_q};
        `MTR_A_TRQ_TGT:   o_rdata <= {16'h0000, trq_tgt_q};
        `MTR_A_TRQ_MAX:   o_rdata <= {16'h0000, trq_max_q};
        `MTR_A_TRQ_DEM:   o_rdata <= {16'h0000, o_trq_demand};
        `MTR_A_TRQ_FB:    o_rdata <= {16'h0000, i_trq_feedback};
        `MTR_A_POS_TGT:   o_rdata <= pos_tgt_q;
        `MTR_A_HOME_OFS:  o_rdata <= home_ofs_q;
        `MTR_A_SIGN_CTL:  o_rdata <= {16'h0000, sign_q};
        `MTR_A_SPD_CAP:   o_rdata <= spd_cap_q;
        `MTR_A_CRUISE:    o_rdata <= cruise_q;
        `MTR_A_LIM_MIN:   o_rdata <= lim_min_q;
        `MTR_A_LIM_MAX:   o_rdata <= lim_max_q;
        `MTR_A_CTRL:      o_rdata <= {16'h0000, ctrl_q};
        `MTR_A_MODE:      o_rdata <= {16'h0000, mode_q};
        `MTR_A_SPD_TGT:   o_rdata <= spd_tgt_q;
        `MTR_A_STATUS:    o_rdata <= {16'h0000, status.home_done, 4'h0, status.speed_reached,
                                      7'h00, status.home_err, status.zero_speed, 1'b0};
        default:          o_rdata <= 32'h00000000;
      endcase
    end else begin
      o_rdata <= 32'h00000000;
    end
  end

  property p_spd_restart;
    @(posedge i_core_clk) disable iff (!i_rstn) !spd_in_win |=> spd_cnt_q == 16'h0000;
  endproperty
  a_spd_restart: assert property (p_spd_restart) else $error("speed counter not restarted"); // see R21

  property p_spd_reached;
    @(posedge i_core_clk) disable iff (!i_rstn) o_speed_reached |-> spd_in_win && spd_cnt_q >= spd_time_q;
  endproperty
  a_spd_reached: assert property (p_spd_reached) else $error("speed reached without qualification"); // see R1

  property p_spd_valid;
    @(posedge i_core_clk) disable iff (!i_rstn) (!is_pv || !ctrl_q[`MTR_CTRL_ENABLE]) |-> !o_speed_reached;
  endproperty
  a_spd_valid: assert property (p_spd_valid) else $error("speed reached outside enabled PV"); // see R2

  property p_zero;
    @(posedge i_core_clk) disable iff (!i_rstn) o_zero_speed |-> is_pv && zero_in_win && zero_cnt_q >= zero_time_q;
  endproperty
  a_zero: assert property (p_zero) else $error("zero speed without qualification"); // see R4 R6

  property p_trq_clamp;
    @(posedge i_core_clk) disable iff (!i_rstn) o_trq_demand <= trq_max_q && o_trq_demand >= -trq_max_q;
  endproperty
  a_trq_clamp: assert property (p_trq_clamp) else $error("torque demand beyond limit"); // see R9

  property p_home_load;
    @(posedge i_core_clk) disable iff (!i_rstn) i_homing_done |=> o_pos_load && o_home_done
                                                && o_pos_load_value == $past(home_ofs_q);
  endproperty
  a_home_load: assert property (p_home_load) else $error("homing load missing"); // see R12 R13

  property p_home_err;
    @(posedge i_core_clk) disable iff (!i_rstn) i_homing_done && home_ofs_q > lim_max_q |=> o_home_error;
  endproperty
  a_home_err: assert property (p_home_err) else $error("home error not raised"); // see R14

  property p_soft_idle;
    @(posedge i_core_clk) disable iff (!i_rstn) !home_done_q |-> !o_soft_limit_hit;
  endproperty
  a_soft_idle: assert property (p_soft_idle) else $error("soft limit before homing"); // see R15

  property p_abs_goal;
    @(posedge i_core_clk) disable iff (!i_rstn) i_new_setpoint && !ctrl_q[`MTR_CTRL_REL] && !sign_q[`MTR_SIGN_POS]
                                                |=> o_pos_goal == $past(pos_tgt_q);
  endproperty
  a_abs_goal: assert property (p_abs_goal) else $error("absolute goal wrong"); // see R10

  property p_cruise;
    @(posedge i_core_clk) disable iff (!i_rstn) !i_new_setpoint |=> $stable(o_cruise_speed);
  endproperty
  a_cruise: assert property (p_cruise) else $error("cruise speed changed early"); // see R20

  property p_spd_cap;
    @(posedge i_core_clk) disable iff (!i_rstn) !spd_cap_q[31]
                                                |-> (o_speed_ref[31] ? -o_speed_ref : o_speed_ref) <= spd_cap_q;
  endproperty
  a_spd_cap: assert property (p_spd_cap) else $error("speed reference beyond cap"); // see R19

  property p_spd_sign;
    @(posedge i_core_clk) disable iff (!i_rstn) sign_q[`MTR_SIGN_SPD] && spd_tgt_q > 32'sh00000000
                                                |-> o_speed_ref <= 32'sh00000000;
  endproperty
  a_spd_sign: assert property (p_spd_sign) else $error("speed reference not inverted"); // see R17

  property p_trq_sign;
    @(posedge i_core_clk) disable iff (!i_rstn) sign_q[`MTR_SIGN_TRQ] && trq_tgt_q > 16'sh0000
                                                |-> o_trq_demand <= 16'sh0000;
  endproperty
  a_trq_sign: assert property (p_trq_sign) else $error("torque demand not inverted"); // see R18

  property p_rel_goal;
    @(posedge i_core_clk) disable iff (!i_rstn) i_new_setpoint && ctrl_q[`MTR_CTRL_REL] && !sign_q[`MTR_SIGN_POS]
                                                |=> o_pos_goal == $past(i_pos_actual) + $past(pos_tgt_q);
  endproperty
  a_rel_goal: assert property (p_rel_goal) else $error("relative goal wrong"); // see R11

  property p_pos_neg;
    @(posedge i_core_clk) disable iff (!i_rstn) i_new_setpoint && !ctrl_q[`MTR_CTRL_REL] && sign_q[`MTR_SIGN_POS]
                                                |=> o_pos_goal == -$past(pos_tgt_q);
  endproperty
  a_pos_neg: assert property (p_pos_neg) else $error("position reference not inverted"); // see R16

  property p_zero_restart;
    @(posedge i_core_clk) disable iff (!i_rstn) !zero_in_win |=> zero_cnt_q == 16'h0000;
  endproperty
  a_zero_restart: assert property (p_zero_restart) else $error("zero counter not restarted"); // see R21

  property p_tick;
    @(posedge i_core_clk) disable iff (!i_rstn) tick |=> tick_cnt_q == 32'h00000000;
  endproperty
  a_tick: assert property (p_tick) else $error("tick divider not wrapped"); // see R21

  property p_herr_clr;
    @(posedge i_core_clk) disable iff (!i_rstn) herr_clr && !i_homing_done |=> !o_home_error;
  endproperty
  a_herr_clr: assert property (p_herr_clr) else $error("home error not cleared"); // see R14
endmodule // mtr_motion_params

// ---- bench/mtr_host_model.sv ----
// Purpose: Host controller model that issues single-cycle register writes and reads.
// Assumes: Strobes change by non-blocking assignment just after a rising edge.
// Notes: Each access leaves one idle cycle behind it and returns just after an edge.
module mtr_host_model (
  input  wire logic         i_core_clk,
  output mtr_pkg::mtr_req_s o_req
);
  timeunit 1ns;
  timeprecision 1ps;

  initial o_req = '0;

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    o_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_core_clk);
    o_req <= '0;
    #1;
  endtask

  task automatic rd(input logic [15:0] a);
    @(posedge i_core_clk);
    o_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge i_core_clk);
    o_req <= '0;
    #1;
  endtask
endmodule // mtr_host_model

// ---- bench/tb_mtr_motion_params.sv ----
// Purpose: Self-checking bench for the motion parameter block.
// Assumes: Millisecond tick shortened to 4 clock cycles.
// Notes: Expected read results are queued by the driver and compared by a monitor.
`include "mtr_defines.svh"
module tb_mtr_motion_params;
  timeunit 1ns;
  timeprecision 1ps;
  logic                clk;
  logic                rstn;
  mtr_pkg::mtr_req_s   req;
  logic [31:0]         rdata;
  logic signed [31:0]  vel, pos, sref, goal, ldv;
  logic signed [15:0]  fb, trq;
  logic                hdone, nsp, reached, zero, ld, hd, herr, hit, rd_seen;
  logic [31:0]         cruise, r;
  logic [31:0]         exp_q[$];
  int                  mismatches, cmp_count, n;
  logic [15:0] ra [16] = '{`MTR_A_VEL_ACT, `MTR_A_SPD_WIN, `MTR_A_SPD_TIME, `MTR_A_ZERO_THR, `MTR_A_ZERO_TIME,
    `MTR_A_TRQ_TGT, `MTR_A_TRQ_MAX, `MTR_A_TRQ_DEM, `MTR_A_TRQ_FB, `MTR_A_POS_TGT, `MTR_A_HOME_OFS,
    `MTR_A_SIGN_CTL, `MTR_A_SPD_CAP, `MTR_A_CRUISE, `MTR_A_LIM_MIN, `MTR_A_LIM_MAX};
  logic [31:0] rv [16] = '{32'h0, 32'h0000000A, 32'h0, 32'h0000000A, 32'h0, 32'h0, 32'h00000DAC, 32'h0, 32'h0,
    32'h0, 32'h0, 32'h0, `MTR_RST_SPD_CAP, `MTR_RST_CRUISE, `MTR_RST_LIM_MIN, `MTR_RST_LIM_MAX};

  mtr_host_model u_mtr_host_model (.i_core_clk(clk), .o_req(req));

  mtr_motion_params #(.TICK_CYCLES(4)) u_mtr_motion_params (
    .i_core_clk(clk), .i_rstn(rstn), .i_req(req), .o_rdata(rdata), .i_vel_actual(vel),
    .i_trq_feedback(fb), .i_pos_actual(pos), .i_homing_done(hdone), .i_new_setpoint(nsp),
    .o_speed_reached(reached), .o_zero_speed(zero), .o_trq_demand(trq), .o_speed_ref(sref),
    .o_pos_goal(goal), .o_cruise_speed(cruise), .o_pos_load(ld), .o_pos_load_value(ldv),
    .o_home_done(hd), .o_home_error(herr), .o_soft_limit_hit(hit)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("mismatches=%0d cmp_count=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic rd_exp(input logic [15:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    u_mtr_host_model.rd(a);
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    u_mtr_host_model.wr(a, d);
  endtask

  task automatic drive(input logic signed [31:0] v, input logic signed [31:0] p);
    @(posedge clk);
    vel <= v;
    pos <= p;
    #1;
  endtask

  task automatic home_pulse();
    @(posedge clk);
    hdone <= 1'b1;
    @(posedge clk);
    hdone <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the read strobe.
  always @(posedge clk) begin
    if (rd_seen) chk(rdata, exp_q.pop_front());
    rd_seen <= req.rd;
  end

  initial begin
    #800000;
    mismatches++;
    give_verdict();
  end

  initial begin
    void'($urandom(32'h8FA6240A));
    rstn = 1'b0; vel = '0; pos = '0; fb = '0; hdone = 1'b0; nsp = 1'b0; rd_seen = 1'b0;
    mismatches = 0; cmp_count = 0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 16; i++) rd_exp(ra[i], rv[i]);
    rd_exp(16'h3600, 32'h0);
    wr(16'h3600, 32'h12345678);
    rd_exp(16'h3600, 32'h0);
    wr(`MTR_A_TRQ_DEM, 32'h00001234);
    rd_exp(`MTR_A_TRQ_DEM, 32'h0);
    for (int i = 0; i < 16; i++) begin
      if (!(i inside {0, 5, 6, 7, 8, 11})) begin
        r = $urandom & ((i < 9) ? 32'h0000FFFF : 32'hFFFFFFFF);
        wr(ra[i], r);
        rd_exp(ra[i], r);
      end
    end
    // Torque path in torque mode.
    wr(`MTR_A_MODE, 32'h00000004);
    wr(`MTR_A_TRQ_TGT, 32'h00001388);
    rd_exp(`MTR_A_TRQ_TGT, 32'h00000FA0);
    wr(`MTR_A_TRQ_TGT, 32'h00000064);
    chk(trq, 32'h00000064);
    wr(`MTR_A_TRQ_MAX, 32'h00000032);
    chk(trq, 32'h00000032);
    wr(`MTR_A_SIGN_CTL, 32'h00000020);
    chk(trq, 32'hFFFFFFCE);
    wr(`MTR_A_SIGN_CTL, 32'h0000001F);
    chk(trq, 32'h00000032);
    rd_exp(`MTR_A_TRQ_DEM, 32'h00000032);
    @(posedge clk) fb <= -16'sd7;
    rd_exp(`MTR_A_TRQ_FB, 32'h0000FFF9);
    // Speed reference, cap and speed reach.
    wr(`MTR_A_SIGN_CTL, 32'h0);
    wr(`MTR_A_MODE, 32'h00000003);
    wr(`MTR_A_CTRL, 32'h00000001);
    rd_exp(`MTR_A_MODE, 32'h00000003);
    rd_exp(`MTR_A_CTRL, 32'h00000001);
    wr(`MTR_A_SPD_WIN, 32'h0000000A);
    wr(`MTR_A_SPD_TIME, 32'h00000002);
    wr(`MTR_A_SPD_TGT, 32'h000003E8);
    rd_exp(`MTR_A_SPD_TGT, 32'h000003E8);
    wr(`MTR_A_SPD_CAP, 32'h00000258);
    chk(sref, 32'h00000258);
    wr(`MTR_A_SPD_CAP, 32'h00001388);
    chk(sref, 32'h000003E8);
    wr(`MTR_A_SIGN_CTL, 32'h00000040);
    chk(sref, 32'hFFFFFC18);
    wr(`MTR_A_SIGN_CTL, 32'h0);
    drive(32'sd1008, 32'sd0);
    chk(reached, 1'b0);
    n = 0;
    while (reached !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n >= 4 && n <= 12, 1'b1);
    drive(32'sd1011, 32'sd0);
    chk(reached, 1'b0);
    drive(32'sd1000, 32'sd0);
    chk(reached, 1'b0);
    n = 0;
    while (reached !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n >= 4 && n <= 12, 1'b1);
    wr(`MTR_A_CTRL, 32'h0);
    chk(reached, 1'b0);
    // Zero speed, drive disabled.
    wr(`MTR_A_ZERO_THR, 32'h0000000A);
    wr(`MTR_A_ZERO_TIME, 32'h0);
    drive(-32'sd10, 32'sd0);
    chk(zero, 1'b1);
    drive(32'sd11, 32'sd0);
    chk(zero, 1'b0);
    drive(32'sd5, 32'sd0);
    chk(zero, 1'b1);
    rd_exp(`MTR_A_STATUS, 32'h00000002);
    wr(`MTR_A_ZERO_TIME, 32'h00000002);
    drive(32'sd20, 32'sd0);
    drive(32'sd3, 32'sd0);
    chk(zero, 1'b0);
    foreach (ra[i]) if (i < 4) begin
      wr(`MTR_A_MODE, (i == 0) ? 32'h1 : (i == 1) ? 32'h4 : (i == 2) ? 32'h6 : 32'h7);
      chk(zero, 1'b0);
    end
    // Position goal and cruise speed.
    wr(`MTR_A_POS_TGT, 32'h000003E8);
    wr(`MTR_A_CRUISE, 32'h00000309);
    chk(cruise, `MTR_RST_CRUISE);
    for (int i = 0; i < 3; i++) begin
      wr(`MTR_A_CTRL, (i == 1) ? 32'h00000040 : 32'h0);
      wr(`MTR_A_SIGN_CTL, (i == 2) ? 32'h00000080 : 32'h0);
      drive(32'sd0, 32'sd300);
      @(posedge clk) nsp <= 1'b1;
      @(posedge clk) nsp <= 1'b0;
      #1;
      chk(goal, (i == 0) ? 32'h000003E8 : (i == 1) ? 32'h00000514 : 32'hFFFFFC18);
      chk(cruise, 32'h00000309);
    end
    // Homing, home offset and soft limits.
    wr(`MTR_A_LIM_MIN, 32'hFFFFFC18);
    wr(`MTR_A_LIM_MAX, 32'h000003E8);
    wr(`MTR_A_CTRL, 32'h00000002);
    drive(32'sd0, 32'sd2000);
    chk(hit, 1'b0);
    wr(`MTR_A_HOME_OFS, 32'h00001388);
    home_pulse();
    chk({ld, hd, herr}, 3'b111);
    chk(ldv, 32'h00001388);
    @(posedge clk);
    #1;
    chk({ld, hd, herr}, 3'b011);
    chk(hit, 1'b1);
    rd_exp(`MTR_A_STATUS, 32'h00008004);
    drive(32'sd0, 32'sd0);
    chk(hit, 1'b0);
    wr(`MTR_A_CTRL, 32'h00000102);
    wr(`MTR_A_HOME_OFS, 32'h00000032);
    chk(herr, 1'b0);
    home_pulse();
    chk({ld, hd, herr}, 3'b110);
    chk(ldv, 32'h00000032);
    repeat (3) @(posedge clk);
    chk(exp_q.size(), 32'h0);
    give_verdict();
  end
endmodule // tb_mtr_motion_params
